// >>> include/sdb_regs.svh
// register map, field positions and link constants of the serial debug unit
`ifndef SDB_REGS_SVH
`define SDB_REGS_SVH
`define SDB_AW          8
`define SDB_OFF_CTRL    8'h00
`define SDB_OFF_STAT    8'h04
`define SDB_OFF_TXD     8'h08
`define SDB_OFF_RXD     8'h0c
`define SDB_OFF_CNTR    8'h10
`define SDB_OFF_BAUD    8'h14
`define SDB_CTRL_W      7
`define SDB_CTRL_RST    7'h00
`define SDB_CB_BRKEN    0
`define SDB_CB_LOOP     1
`define SDB_CB_HALT     2
`define SDB_CB_FULL     3
`define SDB_CB_HIGH     4
`define SDB_CB_MODE_LO  5
`define SDB_CB_MODE_HI  6
`define SDB_SB_LOOP     0
`define SDB_SB_HALT     1
`define SDB_SB_LOCK     2
`define SDB_SB_RXNE     3
`define SDB_SB_REJ      4
`define SDB_SB_TXB      5
`define SDB_BREAK_OP    8'h00
`define SDB_CMD_STAT    8'h5a
`define SDB_CAL_SHIFT   3
`define SDB_DIV_MIN     11'h008
`define SDB_DIV_MAX     11'h200
`define SDB_BREAK_BITS  17'h0000a
`define SDB_STOP_IDX    4'h9
`define SDB_CTR_ONE     16'h0001
`define SDB_RESP_OKAY   2'h0
`define SDB_RESP_SLVERR 2'h2
`endif

// >>> include/sdb_pkg.sv
// state and mode types of the serial debug unit
package sdb_pkg;
  typedef enum logic [1:0] {BD_RESET, BD_MEAS, BD_LOCK} sdb_baud_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} sdb_rx_t;
  typedef enum logic [1:0] {CM_CYCLES, CM_DOWN, CM_MATCH, CM_OFF} sdb_cmode_t;
endpackage

// >>> src/sdb_fifo.sv
// valid/ready fifo holding received link bytes
`timescale 1ns/10ps
module sdb_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]   cnt_q, cnt_d;
  logic          push, pop;
  // flags and pointer advance; depth is a power of two
  always_comb begin
    in_ready  = cnt_q != (AW+1)'(D);
    out_valid = cnt_q != '0;
    out_data  = mem[rp_q];
    push      = in_valid && in_ready;
    pop       = out_valid && out_ready;
    wp_d      = push ? wp_q + 1'b1 : wp_q;
    rp_d      = pop ? rp_q + 1'b1 : rp_q;
    cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end
  // storage and pointers
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
    if (!aresetn) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
  end
endmodule

// >>> src/sdb_top.sv
// serial debug unit: autobaud single-wire link, break control, counter, axi4-lite
//
// Summary of operation
// - ten low bit times reset baud detector
// - host sends 80H, low span sets rate
// - measurement overflow keeps detector in reset
// - bit period between 8 and 512 clocks
// - generator runs at the measured rate
// - full drive: both levels, start to mid-stop
// - high assist: drive high until seen/mid-bit
// - both options: one-clock high pulse per rise
// - breaks disabled: break opcode acts as nop
// - enabled break halts or loops per select
// - status shows looping, pollable over the link
// - return to looped break sets halt flag only with loop select clear
// - commands other than status rejected while looping, not halted
// - break opcode is 00H
// - 16-bit counter: cycles, countdown, pc match
// - cycle count runs only outside debug state
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "sdb_regs.svh"
module sdb_top #(
  parameter int MW    = 14,
  parameter int BW    = 10,
  parameter int DEPTH = 32
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [`SDB_AW-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [`SDB_AW-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              dbg_in,
  output logic                   dbg_out,
  output logic                   dbg_oe,
  input  wire logic              op_valid,
  input  wire logic [7:0]        op_code,
  input  wire logic [15:0]       op_pc,
  output logic                   cpu_halt,
  output logic                   cpu_loop
);
  import sdb_pkg::*;

  // link state
  logic            s1_q, s2_q, s3_q;
  sdb_baud_t       bst_q, bst_d;
  logic [MW-1:0]   mcnt_q, mcnt_d;
  logic [BW-1:0]   baud_q, baud_d;
  logic [16:0]     low_q, low_d;
  sdb_rx_t         rst_q, rst_d;
  logic [BW-1:0]   rph_q, rph_d;
  logic [2:0]      ridx_q, ridx_d;
  logic [7:0]      rsh_q, rsh_d;
  logic            tbusy_q, tbusy_d;
  logic [9:0]      tsh_q, tsh_d;
  logic [3:0]      tidx_q, tidx_d;
  logic [BW-1:0]   tph_q, tph_d;
  logic            tlast_q, tlast_d;
  logic            hiseen_q, hiseen_d;
  logic            pin_out_q, pin_out_d;
  logic            pin_oe_q, pin_oe_d;
  logic            rx_push, rej_evt, stat_go, drive, bitv;
  logic [MW-4:0]   div;
  logic [16:0]     brk_lim;
  logic [BW-1:0]   half;
  // core state
  logic [`SDB_CTRL_W-1:0] debug_control_reg_q, debug_control_reg_d;
  logic            loop_q, loop_d;
  logic [15:0]     lpc_q, lpc_d;
  logic [15:0]     debug_counter_q, debug_counter_d;
  logic            rej_q, rej_d;
  logic            awg_q, awg_d, wg_q, wg_d;
  logic [`SDB_AW-1:0] waddr_q, waddr_d;
  logic [31:0]     wdat_q, wdat_d;
  logic [3:0]      wstb_q, wstb_d;
  logic            awready_q, awready_d, wready_q, wready_d;
  logic            bvalid_q, bvalid_d, rvalid_q, rvalid_d, arready_q, arready_d;
  logic [1:0]      bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]     rdata_q, rdata_d, debug_status_reg;
  logic            wr_fire, hit, hset, sw_go, pop, fifo_ov, fifo_ir;
  logic [7:0]      fifo_od;
  sdb_cmode_t      cmode;

  // decoded address matches a mapped register
  function automatic logic known(input logic [`SDB_AW-1:0] a);
    known = a == `SDB_OFF_CTRL || a == `SDB_OFF_STAT || a == `SDB_OFF_TXD ||
            a == `SDB_OFF_RXD || a == `SDB_OFF_CNTR || a == `SDB_OFF_BAUD;
  endfunction

  assign div     = mcnt_q[MW-1:`SDB_CAL_SHIFT];
  assign brk_lim = 17'(baud_q) * `SDB_BREAK_BITS;
  assign half    = baud_q >> 1;
  assign bitv    = tsh_q[0];
  assign cmode   = sdb_cmode_t'(debug_control_reg_q[`SDB_CB_MODE_HI:`SDB_CB_MODE_LO]);

  // received bytes wait here for software
  sdb_fifo #(.W(8), .D(DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (rx_push),
    .in_ready  (fifo_ir),
    .in_data   (rsh_q),
    .out_valid (fifo_ov),
    .out_ready (pop),
    .out_data  (fifo_od)
  );

  // status word, also the answer to the link status command
  always_comb begin
    debug_status_reg = '0;
    debug_status_reg[`SDB_SB_LOOP] = loop_q;
    debug_status_reg[`SDB_SB_HALT] = debug_control_reg_q[`SDB_CB_HALT];
    debug_status_reg[`SDB_SB_LOCK] = bst_q == BD_LOCK;
    debug_status_reg[`SDB_SB_RXNE] = fifo_ov;
    debug_status_reg[`SDB_SB_REJ]  = rej_q;
    debug_status_reg[`SDB_SB_TXB]  = tbusy_q;
  end

  // link next state: autobaud, receiver, transmitter, pin drive
  always_comb begin
    bst_d    = bst_q;
    mcnt_d   = mcnt_q;
    baud_d   = baud_q;
    low_d    = low_q;
    rst_d    = rst_q;
    rph_d    = rph_q;
    ridx_d   = ridx_q;
    rsh_d    = rsh_q;
    tbusy_d  = tbusy_q;
    tsh_d    = tsh_q;
    tidx_d   = tidx_q;
    tph_d    = tph_q;
    tlast_d  = tlast_q;
    rx_push  = 1'b0;
    rej_evt  = 1'b0;
    stat_go  = 1'b0;
    unique case (bst_q)
      BD_RESET: if (s3_q && !s2_q) begin
        bst_d  = BD_MEAS;
        mcnt_d = MW'(1'b1); // the detecting cycle is already low
      end
      BD_MEAS: if (&mcnt_q) begin
        bst_d = BD_RESET;
      end else if (s2_q) begin
        if (div < `SDB_DIV_MIN || div > `SDB_DIV_MAX) begin
          bst_d = BD_RESET;
        end else begin
          bst_d  = BD_LOCK;
          baud_d = div[BW-1:0];
          low_d  = '0;
        end
      end else begin
        mcnt_d = mcnt_q + 1'b1;
      end
      BD_LOCK: begin
        low_d = s2_q ? '0 : low_q + 1'b1;
        if (!s2_q && low_q == brk_lim) begin
          bst_d = BD_RESET;
        end
      end
    endcase
    unique case (rst_q)
      RX_IDLE: if (bst_q == BD_LOCK && !tbusy_q && s3_q && !s2_q) begin
        rst_d = RX_START;
        rph_d = '0;
      end
      RX_START: if (rph_q == half) begin
        rph_d  = '0;
        ridx_d = '0;
        rst_d  = s2_q ? RX_IDLE : RX_DATA;
      end else begin
        rph_d = rph_q + 1'b1;
      end
      RX_DATA: if (rph_q == baud_q - 1'b1) begin
        rph_d  = '0;
        rsh_d  = {s2_q, rsh_q[7:1]};
        ridx_d = ridx_q + 1'b1;
        if (&ridx_q) begin
          rst_d = RX_STOP;
        end
      end else begin
        rph_d = rph_q + 1'b1;
      end
      RX_STOP: if (rph_q != baud_q - 1'b1) begin
        rph_d = rph_q + 1'b1;
      end else if (rsh_q == `SDB_CMD_STAT) begin
        stat_go = !tbusy_q;
        rst_d   = RX_IDLE;
      end else if (loop_q && !debug_control_reg_q[`SDB_CB_HALT]) begin
        rej_evt = 1'b1;
        rst_d   = RX_IDLE;
      end else begin
        rx_push = 1'b1;
        if (fifo_ir) begin
          rst_d = RX_IDLE;
        end
      end
    endcase
    if (bst_d != BD_LOCK) begin
      rst_d = RX_IDLE;
    end
    if (!tbusy_q) begin
      if (bst_q == BD_LOCK && (stat_go || sw_go)) begin
        tbusy_d = 1'b1;
        tsh_d   = {1'b1, stat_go ? debug_status_reg[7:0] : wdat_q[7:0], 1'b0};
        tidx_d  = '0;
        tph_d   = '0;
        tlast_d = 1'b1;
      end
    end else if (tph_q == baud_q - 1'b1) begin
      tph_d   = '0;
      tlast_d = bitv;
      tsh_d   = {1'b1, tsh_q[9:1]};
      tidx_d  = tidx_q + 1'b1;
      if (tidx_q == `SDB_STOP_IDX) begin
        tbusy_d = 1'b0;
      end
    end else begin
      tph_d = tph_q + 1'b1;
    end
    hiseen_d  = (tph_d == '0) ? 1'b0 : hiseen_q | s2_q;
    // drive ends at mid stop bit
    drive     = tbusy_q && (tidx_q != `SDB_STOP_IDX || tph_q < half);
    pin_out_d = bitv;
    unique case ({debug_control_reg_q[`SDB_CB_FULL], debug_control_reg_q[`SDB_CB_HIGH]})
      2'b11: pin_oe_d = drive && (!bitv || (!tlast_q && tph_q == '0));
      2'b10: pin_oe_d = drive;
      2'b01: pin_oe_d = drive && (!bitv || (tph_q < half && !hiseen_q));
      2'b00: pin_oe_d = drive && !bitv;
    endcase
  end

  // link registers
  always_ff @(posedge aclk) begin
    s1_q <= dbg_in;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (!aresetn) begin
      bst_q     <= BD_RESET;
      mcnt_q    <= '0;
      baud_q    <= '0;
      low_q     <= '0;
      rst_q     <= RX_IDLE;
      rph_q     <= '0;
      ridx_q    <= '0;
      rsh_q     <= '0;
      tbusy_q   <= 1'b0;
      tsh_q     <= '1;
      tidx_q    <= '0;
      tph_q     <= '0;
      tlast_q   <= 1'b1;
      hiseen_q  <= 1'b0;
      pin_out_q <= 1'b0;
      pin_oe_q  <= 1'b0;
    end else begin
      bst_q     <= bst_d;
      mcnt_q    <= mcnt_d;
      baud_q    <= baud_d;
      low_q     <= low_d;
      rst_q     <= rst_d;
      rph_q     <= rph_d;
      ridx_q    <= ridx_d;
      rsh_q     <= rsh_d;
      tbusy_q   <= tbusy_d;
      tsh_q     <= tsh_d;
      tidx_q    <= tidx_d;
      tph_q     <= tph_d;
      tlast_q   <= tlast_d;
      hiseen_q  <= hiseen_d;
      pin_out_q <= pin_out_d;
      pin_oe_q  <= pin_oe_d;
    end
  end

  // core next state: bus slave, break control, counter
  always_comb begin
    awg_d   = awg_q;
    wg_d    = wg_q;
    waddr_d = waddr_q;
    wdat_d  = wdat_q;
    wstb_d  = wstb_q;
    bvalid_d = bvalid_q && !bready;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q && !rready;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    pop      = 1'b0;
    debug_control_reg_d = debug_control_reg_q;
    loop_d  = loop_q;
    lpc_d   = lpc_q;
    debug_counter_d = debug_counter_q;
    rej_d   = rej_q;
    hset    = 1'b0;
    if (awvalid && awready_q) begin
      awg_d   = 1'b1;
      waddr_d = awaddr;
    end
    if (wvalid && wready_q) begin
      wg_d   = 1'b1;
      wdat_d = wdata;
      wstb_d = wstrb;
    end
    wr_fire = awg_q && wg_q && !bvalid_q;
    sw_go   = wr_fire && waddr_q == `SDB_OFF_TXD && wstb_q[0];
    if (wr_fire) begin
      awg_d    = 1'b0;
      wg_d     = 1'b0;
      bvalid_d = 1'b1;
      bresp_d  = known(waddr_q) ? `SDB_RESP_OKAY : `SDB_RESP_SLVERR;
    end
    if (arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = known(araddr) ? `SDB_RESP_OKAY : `SDB_RESP_SLVERR;
      rdata_d  = '0;
      unique case (1'b1)
        araddr == `SDB_OFF_CTRL: rdata_d[`SDB_CTRL_W-1:0] = debug_control_reg_q;
        araddr == `SDB_OFF_STAT: rdata_d = debug_status_reg;
        araddr == `SDB_OFF_RXD:  rdata_d[7:0] = fifo_ov ? fifo_od : 8'h00;
        araddr == `SDB_OFF_CNTR: rdata_d[15:0] = debug_counter_q;
        araddr == `SDB_OFF_BAUD: rdata_d[BW-1:0] = baud_q;
        default: rdata_d = '0;
      endcase
      pop = araddr == `SDB_OFF_RXD && fifo_ov;
    end
    awready_d = !awg_d && !bvalid_d;
    wready_d  = !wg_d && !bvalid_d;
    arready_d = !rvalid_d;
    hit = op_valid && op_code == `SDB_BREAK_OP && debug_control_reg_q[`SDB_CB_BRKEN];
    if (hit && !debug_control_reg_q[`SDB_CB_HALT]) begin
      if (debug_control_reg_q[`SDB_CB_LOOP] && (!loop_q || op_pc == lpc_q)) begin
        loop_d = 1'b1;
        lpc_d  = op_pc;
      end else begin
        hset = 1'b1;
      end
    end
    if (!debug_control_reg_q[`SDB_CB_HALT]) begin
      unique case (cmode)
        CM_CYCLES: debug_counter_d = debug_counter_q + 1'b1;
        CM_DOWN: if (debug_control_reg_q[`SDB_CB_BRKEN]) begin
          debug_counter_d = debug_counter_q - 1'b1;
          hset = hset || debug_counter_q == `SDB_CTR_ONE;
        end
        CM_MATCH: hset = hset || (debug_control_reg_q[`SDB_CB_BRKEN] && op_valid &&
                                  op_pc == debug_counter_q);
        CM_OFF: hset = hset;
      endcase
    end
    if (wr_fire && waddr_q == `SDB_OFF_CTRL && wstb_q[0]) begin
      debug_control_reg_d = wdat_q[`SDB_CTRL_W-1:0];
    end
    if (wr_fire && waddr_q == `SDB_OFF_CNTR) begin
      debug_counter_d[7:0]  = wstb_q[0] ? wdat_q[7:0] : debug_counter_d[7:0];
      debug_counter_d[15:8] = wstb_q[1] ? wdat_q[15:8] : debug_counter_d[15:8];
    end
    if (wr_fire && waddr_q == `SDB_OFF_STAT && wstb_q[0] && wdat_q[`SDB_SB_REJ]) begin
      rej_d = 1'b0;
    end
    // hardware sets win over software clears
    rej_d = rej_d | rej_evt;
    if (hset) begin
      debug_control_reg_d[`SDB_CB_HALT] = 1'b1;
    end
    if (debug_control_reg_d[`SDB_CB_HALT]) begin
      loop_d = 1'b0;
    end
  end

  // core registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awg_q     <= 1'b0;
      wg_q      <= 1'b0;
      waddr_q   <= '0;
      wdat_q    <= '0;
      wstb_q    <= '0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= `SDB_RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= `SDB_RESP_OKAY;
      rdata_q   <= '0;
      debug_control_reg_q <= `SDB_CTRL_RST;
      loop_q    <= 1'b0;
      lpc_q     <= '0;
      debug_counter_q <= '0;
      rej_q     <= 1'b0;
    end else begin
      awg_q     <= awg_d;
      wg_q      <= wg_d;
      waddr_q   <= waddr_d;
      wdat_q    <= wdat_d;
      wstb_q    <= wstb_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      debug_control_reg_q <= debug_control_reg_d;
      loop_q    <= loop_d;
      lpc_q     <= lpc_d;
      debug_counter_q <= debug_counter_d;
      rej_q     <= rej_d;
    end
  end

  // outputs straight from flops
  assign awready  = awready_q;
  assign wready   = wready_q;
  assign bvalid   = bvalid_q;
  assign bresp    = bresp_q;
  assign arready  = arready_q;
  assign rvalid   = rvalid_q;
  assign rresp    = rresp_q;
  assign rdata    = rdata_q;
  assign dbg_out  = pin_out_q;
  assign dbg_oe   = pin_oe_q;
  assign cpu_halt = debug_control_reg_q[`SDB_CB_HALT];
  assign cpu_loop = loop_q;

  // checks
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  break_reset_a: assert property (bst_q == BD_LOCK && !s2_q && low_q == brk_lim |=>
    bst_q == BD_RESET) else $error("break did not reset baud detector");
  meas_ovf_a: assert property (bst_q == BD_MEAS && &mcnt_q |=> bst_q == BD_RESET)
    else $error("overflow adopted a rate");
  rate_range_a: assert property (bst_q == BD_LOCK |-> {1'b0, baud_q} >= `SDB_DIV_MIN &&
    {1'b0, baud_q} <= `SDB_DIV_MAX) else $error("bit period out of range");
  full_drive_a: assert property (tbusy_q && tidx_q < `SDB_STOP_IDX &&
    debug_control_reg_q[`SDB_CB_HIGH:`SDB_CB_FULL] == 2'b01 |=> dbg_oe)
    else $error("full drive released line mid frame");
  line_release_a: assert property (!tbusy_q |=> !dbg_oe)
    else $error("line driven while idle");
  loop_entry_a: assert property (hit && !cpu_halt && !loop_q &&
    debug_control_reg_q[`SDB_CB_LOOP] && !hset && !(wr_fire && waddr_q == `SDB_OFF_CTRL) |=>
    cpu_loop && !cpu_halt) else $error("break did not start loop");
  loop_exit_a: assert property (hit && loop_q && !cpu_halt && op_pc == lpc_q &&
    !debug_control_reg_q[`SDB_CB_LOOP] |=> cpu_halt && !cpu_loop)
    else $error("return to looped break did not halt");
  break_nop_a: assert property (!cpu_loop && !cpu_halt &&
    !debug_control_reg_q[`SDB_CB_BRKEN] && !wr_fire |=> !cpu_loop && !cpu_halt)
    else $error("disabled break changed cpu state");
  count_stop_a: assert property (cpu_halt && !wr_fire |=>
    $stable(debug_counter_q)) else $error("counter ran in debug state");
  reject_a: assert property ((rej_evt |=> rej_q) and
    (cpu_loop && !cpu_halt |-> !rx_push)) else $error("command not rejected while looping");
  lock_c: cover property (bst_q == BD_MEAS ##1 bst_q == BD_LOCK);
  loop_halt_c: cover property (cpu_loop ##[1:200] cpu_halt);
  push_c: cover property (rx_push && fifo_ir);
  stat_c: cover property (stat_go);
endmodule

// >>> dv/sdb_host_model.sv
// host adapter model on the single-wire debug line
`timescale 1ns/10ps
module sdb_host_model (
  input  wire logic aclk,
  input  wire logic dbg_out,
  input  wire logic dbg_oe,
  output logic      line
);
  logic host_low = 1'b0;
  logic saw_hi   = 1'b0;
  // pull-up holds the line high unless a party pulls it low
  assign line = dbg_oe ? dbg_out : !host_low;
  // notes any active high drive by the device
  always @(posedge aclk) begin
    if (dbg_oe && dbg_out)
      saw_hi <= 1'b1;
  end
  // 8n1 frame, lsb first, open-drain low only
  task automatic send(input logic [7:0] b, input int per);
    for (int i = 0; i < 10; i++) begin
      host_low <= (i == 0) ? 1'b1 : (i == 9) ? 1'b0 : !b[i-1];
      repeat (per) @(posedge aclk);
    end
  endtask
  // serial break: low for n clocks
  task automatic hold_low(input int n);
    host_low <= 1'b1;
    repeat (n) @(posedge aclk);
    host_low <= 1'b0;
  endtask
  // waits for device drive, samples each bit mid-bit
  task automatic recv(input int per, output logic [7:0] b);
    int t;
    t = 0;
    while (dbg_oe !== 1'b1 && t < 8000) begin
      @(posedge aclk);
      t++;
    end
    repeat (per / 2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      repeat (per) @(posedge aclk);
      b[i] = line;
    end
    // returns at the end of the stop bit, once the device is idle again
    repeat (per + per / 2) @(posedge aclk);
  endtask
endmodule

// >>> dv/tb_serial_debug_break_unit.sv
// testbench of the serial debug unit: register rows, link, break and counter cases
`timescale 1ns/10ps
`include "sdb_regs.svh"
module tb_serial_debug_break_unit;
  typedef struct {
    logic [7:0] a; logic [31:0] d; logic [1:0] wr; logic [31:0] rv; logic [1:0] rr;
  } sdb_row_t;
  localparam int PER = 16;
  localparam logic [1:0] OK = `SDB_RESP_OKAY;
  localparam logic [1:0] SE = `SDB_RESP_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0, op_valid = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, op_code = 8'h00, b;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, v, v0;
  logic [3:0]  wstrb = 4'hf;
  logic [15:0] op_pc = 16'h0;
  logic        awready, wready, bvalid, arready, rvalid, dbg_out, dbg_oe, cpu_halt, cpu_loop;
  logic        line;
  logic [1:0]  bresp, rresp, r;
  int          err_total = 0, n_tests = 0, cyc = 0;
  sdb_row_t rows [4] = '{
    '{`SDB_OFF_CTRL, 32'h78, OK, 32'h78, OK},
    '{`SDB_OFF_CNTR, 32'h1234, OK, 32'h1234, OK},
    '{`SDB_OFF_STAT, 32'hff, OK, 32'h0, OK},
    '{8'h20, 32'h1, SE, 32'h0, SE}
  };
  sdb_top dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .dbg_in(line), .dbg_out(dbg_out), .dbg_oe(dbg_oe), .op_valid(op_valid),
    .op_code(op_code), .op_pc(op_pc), .cpu_halt(cpu_halt), .cpu_loop(cpu_loop));
  sdb_host_model host_u (.aclk(aclk), .dbg_out(dbg_out), .dbg_oe(dbg_oe), .line(line));
  // clock and hang guard
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // axi4-lite write, response code left in r
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    r = bresp;
  endtask
  // axi4-lite read into v and r
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    v = rdata;
    r = rresp;
  endtask
  // one executed opcode at pc, a break unless told otherwise
  task automatic op(input logic [15:0] pc, input logic [7:0] c = `SDB_BREAK_OP);
    @(posedge aclk);
    op_valid <= 1'b1;
    op_code <= c;
    op_pc <= pc;
    @(posedge aclk);
    op_valid <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask
  initial begin
    do_reset();
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      chk(r, rows[i].wr);
      rd(rows[i].a);
      chk(v, rows[i].rv);
      chk(r, rows[i].rr);
    end
    // second reset in mid-run clears control
    do_reset();
    rd(`SDB_OFF_CTRL);
    chk(v, 32'h0);
    // calibration at a legal period locks the generator
    host_u.send(8'h80, PER);
    rd(`SDB_OFF_STAT);
    chk(v[`SDB_SB_LOCK], 1);
    rd(`SDB_OFF_BAUD);
    chk(v, PER);
    // loop on break, status polled over the link
    wr(`SDB_OFF_CTRL, 32'h3);
    op(16'h0100);
    chk(cpu_loop, 1);
    host_u.saw_hi = 1'b0;
    fork
      host_u.send(`SDB_CMD_STAT, PER);
      host_u.recv(PER, b);
    join
    chk(b[`SDB_SB_LOOP], 1);
    chk(host_u.saw_hi, 0);
    host_u.send(8'h33, PER);
    rd(`SDB_OFF_STAT);
    chk(v[`SDB_SB_REJ], 1);
    wr(`SDB_OFF_STAT, 32'h10);
    // clearing loop select, then return to the same break
    wr(`SDB_OFF_CTRL, 32'h1);
    op(16'h0100);
    chk(cpu_halt, 1);
    chk(cpu_loop, 0);
    // breaks disabled: opcode acts as no-op
    wr(`SDB_OFF_CTRL, 32'h0);
    op(16'h0200);
    chk({cpu_halt, cpu_loop}, 0);
    // drain, fill past depth with no reader, then drain in order
    rd(`SDB_OFF_STAT);
    for (int k = 0; k < 40 && v[`SDB_SB_RXNE]; k++) begin
      rd(`SDB_OFF_RXD);
      rd(`SDB_OFF_STAT);
    end
    for (int k = 0; k < 33; k++) host_u.send(k, PER);
    for (int k = 0; k < 32; k++) begin
      rd(`SDB_OFF_RXD);
      chk(v, k);
    end
    // full drive: both levels during a sent frame
    wr(`SDB_OFF_CTRL, 32'h8);
    host_u.saw_hi = 1'b0;
    fork
      wr(`SDB_OFF_TXD, 32'ha5);
      host_u.recv(PER, b);
    join
    chk(b, 8'ha5);
    chk(host_u.saw_hi, 1);
    // high assist, then both options: frame intact, line driven high
    for (int m = 0; m < 2; m++) begin
      wr(`SDB_OFF_CTRL, m ? 32'h18 : 32'h10);
      host_u.saw_hi = 1'b0;
      fork
        wr(`SDB_OFF_TXD, 32'h3c);
        host_u.recv(PER, b);
      join
      chk(b, 8'h3c);
      chk(host_u.saw_hi, 1);
    end
    // countdown reaching zero halts
    wr(`SDB_OFF_CNTR, 32'h8);
    wr(`SDB_OFF_CTRL, 32'h21);
    repeat (40) @(posedge aclk);
    chk(cpu_halt, 1);
    // cycle count frozen in debug state
    wr(`SDB_OFF_CTRL, 32'h4);
    rd(`SDB_OFF_CNTR);
    v0 = v;
    rd(`SDB_OFF_CNTR);
    chk(v, v0);
    // counter equal to an executed pc raises a break
    wr(`SDB_OFF_CNTR, 32'h0300);
    wr(`SDB_OFF_CTRL, 32'h41);
    op(16'h0301, 8'h12);
    chk(cpu_halt, 0);
    op(16'h0300, 8'h12);
    chk(cpu_halt, 1);
    // serial break drops the lock
    host_u.hold_low(12 * PER);
    rd(`SDB_OFF_STAT);
    chk(v[`SDB_SB_LOCK], 0);
    // overflowing and too fast calibrations stay unlocked
    host_u.send(8'h80, 2100);
    rd(`SDB_OFF_STAT);
    chk(v[`SDB_SB_LOCK], 0);
    host_u.send(8'h80, 4);
    rd(`SDB_OFF_STAT);
    chk(v[`SDB_SB_LOCK], 0);
    stop_test();
  end
endmodule
